// ===== verilog/sctp_map.svh
// Register offsets, field positions and reset values of the timer block
`ifndef SCTP_MAP_SVH
`define SCTP_MAP_SVH
// Register byte offsets (low address byte)
`define SCTP_CONFIG 8'h00
`define SCTP_CTRL 8'h04
`define SCTP_COUNT 8'h08
`define SCTP_STATE 8'h0C
`define SCTP_INSEL 8'h10
`define SCTP_REGMODE 8'h14
`define SCTP_OUTPUT 8'h18
`define SCTP_ADCSEL 8'h1C
`define SCTP_EVFLAG 8'h20
`define SCTP_EVEN 8'h24
`define SCTP_MATCH_BASE 8'h40
`define SCTP_MATCH_END 8'h60
`define SCTP_EV_BASE 8'h80
`define SCTP_EV_END 8'hC0
// Configuration fields
`define CFG_UNIFY 0
`define CFG_CLKIN_L 1
`define CFG_CLKIN_H 2
`define CFG_CLKSEL 3
`define CFG_AUTOLIM_L 5
`define CFG_AUTOLIM_H 6
`define CFG_W 7
// Control fields
`define CTL_HALT_L 0
`define CTL_STOP_L 1
`define CTL_BIDIR_L 2
`define CTL_HALT_H 3
`define CTL_STOP_H 4
`define CTL_BIDIR_H 5
`define CTL_RST 6'h09
// Event configuration fields
`define EVC_MSEL 0
`define EVC_IOCOND 3
`define EVC_IOSEL 5
`define EVC_COMB 9
`define EVC_HSEL 11
`define EVC_STLD 12
`define EVC_STVAL 13
`define EVC_DIRQ 16
`define EVC_HOLD 18
`define EVC_SMASK 19
// Event action fields
`define EVA_TOG 0
`define EVA_LIM 6
`define EVA_HALT 7
`define EVA_START 8
`define EVA_STOP 9
`define EVA_DIRCHG 10
`define EVA_STCHG 11
`define EVA_CAP 12
// Event enable register: DMA enables start here
`define EVEN_DMA 8
`endif

// ===== verilog/sctp_pkg.sv
// Types shared by the timer block
package sctp_pkg;
	typedef enum logic [1:0] {
		SCTP_IO_LOW = 2'b00,
		SCTP_IO_RISE = 2'b01,
		SCTP_IO_FALL = 2'b10,
		SCTP_IO_HIGH = 2'b11
	} sctp_iocond_t;
	typedef enum logic [1:0] {
		SCTP_CB_OR = 2'b00,
		SCTP_CB_MATCH = 2'b01,
		SCTP_CB_IO = 2'b10,
		SCTP_CB_AND = 2'b11
	} sctp_comb_t;
	typedef enum logic [1:0] {
		SCTP_DQ_ANY = 2'b00,
		SCTP_DQ_UP = 2'b01,
		SCTP_DQ_DOWN = 2'b10,
		SCTP_DQ_NONE = 2'b11
	} sctp_dirq_t;
endpackage

// ===== verilog/sctp_top.sv
// State-configurable counter/timer and PWM generator with AHB-Lite slave
//
// Functional notes
// (R1) Counter runs as two 16-bit halves or one 32-bit counter.
// (R2) Each half counts system clocks or rising edges of a chosen input.
// (R3) Each half counts up only or up then down.
// (R4) Eight registers, each set to match or capture role.
// (R5) Match can interrupt, stop, limit, halt, reverse or toggle outputs.
// (R6) Capture register loads the count on match or I/O events.
// (R7) Six outputs give PWM with own duty and shared period.
// (R8) Event is match, I/O edge or level, or their combination.
// (R9) Events can limit, halt, start, stop or reverse a counter.
// (R10) Events trigger state change, output toggles, interrupt and DMA requests.
// (R11) Match register 0 acts as automatic limit when enabled.
// (R12) In bidirectional mode events can be qualified by count direction.
// (R13) Match part of an event can be held until another event.
// (R14) State changes on enabled event; each event has a state mask.
// (R15) State persists across counter periods.
// (R16) Four inputs each select one source; inputs up to 25 MHz.
// (R17) Six timer outputs go to the pin switch matrix.
// (R18) One selected match drives the converter trigger.
// (R19) All input selectors offer the same seven sources.
// (R20) Up-down counter reverses at limit, turns up again at zero.
`timescale 1ns/1ps
`include "sctp_map.svh"
module sctp_top
	import sctp_pkg::*;
#(
	parameter int NREG = 8,
	parameter int NEV = 8,
	parameter int NIN = 4,
	parameter int NOUT = 6
)
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Input sources
	input wire logic [3:0] i_pins,
	input wire logic i_adc_thcmp,
	input wire logic i_core_transmit_event,
	input wire logic i_core_a,
	// Timer outputs and requests
	output logic [NOUT-1:0] o_out,
	output logic o_irq,
	output logic o_dma,
	output logic o_adc_trig
);
	// Bus and register state
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [`CFG_W-1:0] cfg;
	logic [1:0] halt, stop, bidir, down;
	logic [31:0] cnt;
	logic [2:0] state;
	logic [NIN*3-1:0] insel;
	logic [NREG-1:0] regmode;
	logic [2:0] adcsel;
	logic [NEV-1:0] evflag, irq_en, dma_en, hold;
	logic [31:0] mr [NREG];
	logic [31:0] evcfg [NEV];
	logic [31:0] evact [NEV];
	// Input path
	logic [6:0] raw_s1, raw_s2;
	logic [NIN-1:0] tin, tin_prev;
	logic [NOUT-1:0] out_prev;
	// Derived signals
	logic [NREG-1:0] mhit_l, mhit_h, mflag;
	logic [1:0] tick, run, evok, lim_hit, zero;
	logic [NEV-1:0] ev_fire;
	logic [NOUT-1:0] tog;
	logic [1:0] a_lim, a_halt, a_start, a_stop, a_dir;
	logic [NREG-1:0] cap;
	logic st_chg;
	logic [2:0] next_state;
	logic [31:0] rd;
	logic unify;

	assign unify = cfg[`CFG_UNIFY];

	// Address decode helper shared by read and write paths
	function automatic logic f_in(input logic [7:0] a, input logic [7:0] lo,
		input logic [7:0] hi);
		f_in = (a >= lo) && (a < hi);
	endfunction

	// Counter step including limit and reversal
	function automatic logic [31:0] f_step(input logic [31:0] v,
		input logic dn, input logic lim, input logic zr, input logic bi);
		if (lim && !dn)
			f_step = bi ? v - 32'h1 : 32'h0; // see (R20)
		else if (dn && zr)
			f_step = v + 32'h1;
		else
			f_step = dn ? v - 32'h1 : v + 32'h1;
	endfunction

	// Bus address phase, zero wait states, always OKAY
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			o_hrdata <= 32'h0;
			o_hreadyout <= 1'b0;
			o_hresp <= 1'b0;
		end
		else
		begin
			o_hreadyout <= 1'b1;
			wr_pend <= i_hsel && i_htrans[1] && i_hready && i_hwrite;
			wr_addr <= i_haddr[7:0];
			if (i_hsel && i_htrans[1] && i_hready && !i_hwrite)
				o_hrdata <= rd;
		end
	end

	// Read multiplexer
	always_comb
	begin
		rd = 32'h0;
		if (i_haddr[7:0] == `SCTP_CONFIG)
			rd[`CFG_W-1:0] = cfg;
		else if (i_haddr[7:0] == `SCTP_CTRL)
			rd[5:0] = {bidir[1], stop[1], halt[1], bidir[0], stop[0], halt[0]};
		else if (i_haddr[7:0] == `SCTP_COUNT)
			rd = cnt;
		else if (i_haddr[7:0] == `SCTP_STATE)
			rd[2:0] = state;
		else if (i_haddr[7:0] == `SCTP_INSEL)
			rd[NIN*3-1:0] = insel;
		else if (i_haddr[7:0] == `SCTP_REGMODE)
			rd[NREG-1:0] = regmode;
		else if (i_haddr[7:0] == `SCTP_OUTPUT)
			rd[NOUT-1:0] = o_out;
		else if (i_haddr[7:0] == `SCTP_ADCSEL)
			rd[2:0] = adcsel;
		else if (i_haddr[7:0] == `SCTP_EVFLAG)
			rd[NEV-1:0] = evflag;
		else if (i_haddr[7:0] == `SCTP_EVEN)
			rd[15:0] = {dma_en, irq_en};
		else if (f_in(i_haddr[7:0], `SCTP_MATCH_BASE, `SCTP_MATCH_END))
			rd = mr[i_haddr[4:2]];
		else if (f_in(i_haddr[7:0], `SCTP_EV_BASE, `SCTP_EV_END))
			rd = i_haddr[2] ? evact[i_haddr[5:3]] : evcfg[i_haddr[5:3]];
	end

	// Plain configuration registers
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cfg <= '0;
			insel <= '0;
			regmode <= '0;
			adcsel <= 3'h0;
			irq_en <= '0;
			dma_en <= '0;
			for (int e = 0; e < NEV; e++)
			begin
				evcfg[e] <= 32'h0;
				evact[e] <= 32'h0;
			end
		end
		else if (wr_pend)
		begin
			if (wr_addr == `SCTP_CONFIG)
				cfg <= i_hwdata[`CFG_W-1:0];
			else if (wr_addr == `SCTP_INSEL)
				insel <= i_hwdata[NIN*3-1:0];
			else if (wr_addr == `SCTP_REGMODE)
				regmode <= i_hwdata[NREG-1:0]; // see (R4)
			else if (wr_addr == `SCTP_ADCSEL)
				adcsel <= i_hwdata[2:0];
			else if (wr_addr == `SCTP_EVEN)
				{dma_en, irq_en} <= i_hwdata[15:0];
			else if (f_in(wr_addr, `SCTP_EV_BASE, `SCTP_EV_END))
			begin
				if (wr_addr[2])
					evact[wr_addr[5:3]] <= i_hwdata;
				else
					evcfg[wr_addr[5:3]] <= i_hwdata;
			end
		end
	end

	// Two-flop synchronisers, then the input selectors
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			raw_s1 <= 7'h00;
			raw_s2 <= 7'h00;
			tin_prev <= '0;
			out_prev <= '0;
		end
		else
		begin
			raw_s1 <= {i_core_a, i_core_transmit_event, i_adc_thcmp, i_pins};
			raw_s2 <= raw_s1; // see (R16)
			tin_prev <= tin;
			out_prev <= o_out;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++)
		begin : g_in
			// Same seven sources for every input; code 7 selects zero
			assign tin[gi] = (insel[gi*3 +: 3] == 3'h7) ? 1'b0 :
				raw_s2[insel[gi*3 +: 3]]; // see (R19)
		end
		for (gi = 0; gi < NREG; gi++)
		begin : g_cmp
			assign mhit_l[gi] = cnt[15:0] == mr[gi][15:0];
			assign mhit_h[gi] = cnt[31:16] == mr[gi][31:16];
			assign mflag[gi] = !regmode[gi] &&
				(unify ? mhit_l[gi] && mhit_h[gi] : mhit_l[gi]);
		end
	endgenerate

	// Count clock source, limit and zero per half
	always_comb
	begin
		tick[0] = cfg[`CFG_CLKIN_L] ?
			tin[cfg[`CFG_CLKSEL +: 2]] && !tin_prev[cfg[`CFG_CLKSEL +: 2]] :
			1'b1; // see (R2)
		tick[1] = cfg[`CFG_CLKIN_H] ?
			tin[cfg[`CFG_CLKSEL +: 2]] && !tin_prev[cfg[`CFG_CLKSEL +: 2]] :
			1'b1;
		evok = tick & ~halt;
		run = tick & ~halt & ~stop;
		zero[0] = unify ? cnt == 32'h0 : cnt[15:0] == 16'h0;
		zero[1] = cnt[31:16] == 16'h0;
		lim_hit[0] = (cfg[`CFG_AUTOLIM_L] && mflag[0]) || a_lim[0]; // see (R11)
		lim_hit[1] = (cfg[`CFG_AUTOLIM_H] && !regmode[0] && mhit_h[0]) ||
			a_lim[1];
	end

	// Event evaluation and action gathering
	always_comb
	begin
		logic h, m, io_now, io_prev, c, dok;
		logic [3:0] s;
		ev_fire = '0;
		tog = '0;
		a_lim = 2'b00;
		a_halt = 2'b00;
		a_start = 2'b00;
		a_stop = 2'b00;
		a_dir = 2'b00;
		cap = '0;
		st_chg = 1'b0;
		next_state = state;
		h = 1'b0;
		m = 1'b0;
		io_now = 1'b0;
		io_prev = 1'b0;
		c = 1'b0;
		dok = 1'b0;
		s = 4'h0;
		for (int e = 0; e < NEV; e++)
		begin
			h = unify ? 1'b0 : evcfg[e][`EVC_HSEL];
			m = (unify ? mhit_l[evcfg[e][`EVC_MSEL +: 3]] &&
				mhit_h[evcfg[e][`EVC_MSEL +: 3]] :
				(h ? mhit_h[evcfg[e][`EVC_MSEL +: 3]] :
				mhit_l[evcfg[e][`EVC_MSEL +: 3]])) &&
				!regmode[evcfg[e][`EVC_MSEL +: 3]];
			m = m || hold[e]; // see (R13)
			s = evcfg[e][`EVC_IOSEL +: 4];
			if (s < 4'(NIN))
			begin
				io_now = tin[s[1:0]];
				io_prev = tin_prev[s[1:0]];
			end
			else if (s < 4'(NIN + NOUT))
			begin
				io_now = o_out[3'(s - 4'(NIN))];
				io_prev = out_prev[3'(s - 4'(NIN))];
			end
			else
			begin
				io_now = 1'b0;
				io_prev = 1'b0;
			end
			case (sctp_iocond_t'(evcfg[e][`EVC_IOCOND +: 2]))
				SCTP_IO_LOW: c = !io_now;
				SCTP_IO_RISE: c = io_now && !io_prev;
				SCTP_IO_FALL: c = !io_now && io_prev;
				default: c = io_now;
			endcase
			case (sctp_comb_t'(evcfg[e][`EVC_COMB +: 2]))
				SCTP_CB_OR: c = m || c; // see (R8)
				SCTP_CB_MATCH: c = m;
				SCTP_CB_IO: c = c;
				default: c = m && c;
			endcase
			case (sctp_dirq_t'(evcfg[e][`EVC_DIRQ +: 2]))
				SCTP_DQ_ANY: dok = 1'b1;
				SCTP_DQ_UP: dok = !bidir[h] || !down[h]; // see (R12)
				SCTP_DQ_DOWN: dok = !bidir[h] || down[h];
				default: dok = 1'b0;
			endcase
			ev_fire[e] = c && dok && evok[h] &&
				evcfg[e][`EVC_SMASK + state]; // see (R14)
			if (ev_fire[e])
			begin
				tog = tog ^ evact[e][`EVA_TOG +: NOUT]; // see (R7)
				a_lim[h] = a_lim[h] | evact[e][`EVA_LIM]; // see (R9)
				a_halt[h] = a_halt[h] | evact[e][`EVA_HALT];
				a_start[h] = a_start[h] | evact[e][`EVA_START];
				a_stop[h] = a_stop[h] | evact[e][`EVA_STOP];
				a_dir[h] = a_dir[h] ^ evact[e][`EVA_DIRCHG];
				cap = cap | evact[e][`EVA_CAP +: NREG];
				if (evact[e][`EVA_STCHG])
				begin
					st_chg = 1'b1;
					next_state = evcfg[e][`EVC_STLD] ?
						evcfg[e][`EVC_STVAL +: 3] :
						state + evcfg[e][`EVC_STVAL +: 3]; // see (R10)
				end
			end
		end
	end

	// Held match terms clear when any other event fires
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			hold <= '0;
		else
			for (int e = 0; e < NEV; e++)
				hold[e] <= evcfg[e][`EVC_HOLD] && ((hold[e] ||
					(ev_fire[e] && !hold[e])) &&
					!(|(ev_fire & ~(NEV'(1) << e)))); // see (R13)
	end

	// Run control: software writes, events halt, start and stop
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			{bidir[1], stop[1], halt[1], bidir[0], stop[0], halt[0]} <=
				`CTL_RST;
		else if (wr_pend && wr_addr == `SCTP_CTRL)
		begin
			halt <= {i_hwdata[`CTL_HALT_H], i_hwdata[`CTL_HALT_L]};
			stop <= {i_hwdata[`CTL_STOP_H], i_hwdata[`CTL_STOP_L]};
			bidir <= {i_hwdata[`CTL_BIDIR_H], i_hwdata[`CTL_BIDIR_L]}; // see (R3)
		end
		else
		begin
			halt <= (halt | a_halt) & ~a_start; // see (R9)
			stop <= (stop | a_stop) & ~a_start;
		end
	end

	// Counter halves, joined with a carry when unified
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt <= 32'h0;
			down <= 2'b00;
		end
		else if (wr_pend && wr_addr == `SCTP_COUNT)
		begin
			cnt <= i_hwdata;
			down <= 2'b00;
		end
		else
		begin
			for (int h = 0; h < 2; h++)
			begin
				if (run[h] && bidir[h] && lim_hit[h] && !down[h])
					down[h] <= 1'b1; // see (R20)
				else if (run[h] && down[h] && zero[h])
					down[h] <= 1'b0;
				else if (!bidir[h])
					down[h] <= 1'b0;
				else if (a_dir[h])
					down[h] <= !down[h]; // see (R5)
			end
			if (unify)
			begin
				if (run[0])
					cnt <= f_step(cnt, down[0], lim_hit[0], zero[0],
						bidir[0]); // see (R1)
			end
			else
			begin
				if (run[0])
					cnt[15:0] <= 16'(f_step({16'h0, cnt[15:0]}, down[0],
						lim_hit[0], zero[0], bidir[0]));
				if (run[1])
					cnt[31:16] <= 16'(f_step({16'h0, cnt[31:16]}, down[1],
						lim_hit[1], zero[1], bidir[1]));
			end
		end
	end

	// Match and capture registers
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			for (int i = 0; i < NREG; i++)
				mr[i] <= 32'h0;
		else
			for (int i = 0; i < NREG; i++)
				if (regmode[i] && cap[i])
					mr[i] <= cnt; // see (R6)
				else if (wr_pend && wr_addr ==
					8'(`SCTP_MATCH_BASE + 4 * i))
					mr[i] <= i_hwdata;
	end

	// State variable; never reset by the counter wrapping
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			state <= 3'h0;
		else if (st_chg)
			state <= next_state; // see (R15)
		else if (wr_pend && wr_addr == `SCTP_STATE)
			state <= i_hwdata[2:0];
	end

	// Outputs, event flags and request pulses
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_out <= '0;
			evflag <= '0;
			o_irq <= 1'b0;
			o_dma <= 1'b0;
			o_adc_trig <= 1'b0;
		end
		else
		begin
			if (wr_pend && wr_addr == `SCTP_OUTPUT)
				o_out <= i_hwdata[NOUT-1:0];
			else
				o_out <= o_out ^ tog; // see (R17)
			if (wr_pend && wr_addr == `SCTP_EVFLAG)
				evflag <= (evflag & ~i_hwdata[NEV-1:0]) | ev_fire;
			else
				evflag <= evflag | ev_fire;
			o_irq <= |(ev_fire & irq_en); // see (R10)
			o_dma <= |(ev_fire & dma_en);
			o_adc_trig <= mflag[adcsel]; // see (R18)
		end
	end

	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_unify_wrap;
		unify && run[0] && !down[0] && !lim_hit[0] && !wr_pend &&
			cnt[15:0] == 16'hFFFF;
	endsequence
	property p_unify_carry;
		s_unify_wrap |=> cnt[31:16] == $past(cnt[31:16]) + 16'h1;
	endproperty
	a_unify_carry: assert property (p_unify_carry) // see (R1)
		else $error("unified carry missed");

	property p_halt_hold;
		halt[0] && !unify && !wr_pend |=> cnt[15:0] == $past(cnt[15:0]);
	endproperty
	a_halt_hold: assert property (p_halt_hold) // see (R9)
		else $error("halted counter moved");

	property p_autolim;
		unify && run[0] && !bidir[0] && cfg[`CFG_AUTOLIM_L] && mflag[0] &&
			!wr_pend |=> cnt == 32'h0;
	endproperty
	a_autolim: assert property (p_autolim) // see (R11)
		else $error("auto limit did not clear counter");

	sequence s_top_turn;
		run[0] && bidir[0] && !down[0] && lim_hit[0] && !wr_pend;
	endsequence
	property p_reverse;
		s_top_turn |=> down[0] ##0 (!run[0] || down[0]);
	endproperty
	a_reverse: assert property (p_reverse) // see (R20)
		else $error("no reversal at limit");

	property p_toggle;
		!wr_pend |=> o_out == ($past(o_out) ^ $past(tog));
	endproperty
	a_toggle: assert property (p_toggle) // see (R7)
		else $error("output toggle wrong");

	property p_irq;
		|(ev_fire & irq_en) |=> o_irq ##1 (o_irq == $past(|(ev_fire & irq_en)));
	endproperty
	a_irq: assert property (p_irq) // see (R10)
		else $error("interrupt request missing");

	property p_capture;
		regmode[1] && cap[1] |=> mr[1] == $past(cnt);
	endproperty
	a_capture: assert property (p_capture) // see (R6)
		else $error("capture did not load count");

	sequence s_state_ev;
		st_chg;
	endsequence
	property p_state;
		s_state_ev |=> state == $past(next_state);
	endproperty
	a_state: assert property (p_state) // see (R14)
		else $error("state did not follow event");

	property p_adc;
		mflag[adcsel] && $stable(adcsel) |=> o_adc_trig;
	endproperty
	a_adc: assert property (p_adc) // see (R18)
		else $error("converter trigger missing");

	property p_flag_set_wins;
		|ev_fire |=> (evflag & $past(ev_fire)) == $past(ev_fire);
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins) // see (R10)
		else $error("event flag lost");
endmodule

// ===== dv/sctp_far_model.sv
// Far-side model: timer input sources and tallies of timer requests
`timescale 1ns/1ps
module sctp_far_model
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Pulse control from the bench
	input wire logic [2:0] i_src,
	input wire logic [2:0] i_width,
	input wire logic i_go,
	input wire logic i_clr,
	// Requests from the timer
	input wire logic i_irq,
	input wire logic i_dma,
	input wire logic i_adc,
	// Source lines and tallies
	output logic [3:0] o_pins,
	output logic o_thcmp,
	output logic o_txev,
	output logic o_halt,
	output logic [7:0] o_n_irq,
	output logic [7:0] o_n_dma,
	output logic [7:0] o_n_adc
);
	logic [2:0] left;
	logic adc_q;
	logic hi;

	// Pulse length; at least one cycle high keeps within the input rate
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			left <= 3'h0;
		else if (i_go)
			left <= i_width;
		else if (left != 3'h0)
			left <= left - 3'h1;
	end

	// Only the chosen source moves, the rest rest low
	assign hi = (left != 3'h0);
	assign o_pins = (hi && i_src < 3'h4) ? 4'(1 << i_src) : 4'h0;
	assign o_thcmp = hi && (i_src == 3'h4);
	assign o_txev = hi && (i_src == 3'h5);
	assign o_halt = hi && (i_src == 3'h6);

	// Edge memory of the converter trigger
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			adc_q <= 1'b0;
		else
			adc_q <= i_adc;
	end

	// Tallies of request pulses and trigger rises
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_n_irq <= 8'h00;
			o_n_dma <= 8'h00;
			o_n_adc <= 8'h00;
		end
		else if (i_clr)
		begin
			o_n_irq <= 8'h00;
			o_n_dma <= 8'h00;
			o_n_adc <= 8'h00;
		end
		else
		begin
			o_n_irq <= o_n_irq + 8'(i_irq);
			o_n_dma <= o_n_dma + 8'(i_dma);
			o_n_adc <= o_n_adc + 8'(i_adc && !adc_q);
		end
	end
endmodule

// ===== dv/tb_top.sv
// Self-checking testbench of the timer block
`timescale 1ns/1ps
`include "sctp_map.svh"
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic [3:0] pins;
	logic thcmp;
	logic txev;
	logic halt;
	logic [5:0] outs;
	logic irq;
	logic dma;
	logic adc;
	logic [2:0] src = 3'h0;
	logic [2:0] width = 3'h1;
	logic go = 1'b0;
	logic clr = 1'b0;
	logic [7:0] n_irq;
	logic [7:0] n_dma;
	logic [7:0] n_adc;
	int n_errors = 0;
	int checks_done = 0;
	int seed = 72515;
	logic [31:0] rd;
	logic [31:0] n;
	logic [31:0] prev;
	logic down;

	// System clock
	always #10 clk = ~clk;

	sctp_top i_sctp_top (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_pins(pins), .i_adc_thcmp(thcmp),
		.i_core_transmit_event(txev), .i_core_a(halt),
		.o_out(outs), .o_irq(irq), .o_dma(dma), .o_adc_trig(adc)
	);

	sctp_far_model i_sctp_far_model (
		.i_clk(clk), .i_rst_n(rst_n), .i_src(src), .i_width(width),
		.i_go(go), .i_clr(clr), .i_irq(irq), .i_dma(dma),
		.i_adc(adc), .o_pins(pins), .o_thcmp(thcmp), .o_txev(txev),
		.o_halt(halt), .o_n_irq(n_irq), .o_n_dma(n_dma),
		.o_n_adc(n_adc)
	);

	// Compare and tally
	task automatic chk(input string w, input logic [31:0] got, e);
		checks_done++;
		if (got !== e)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", w, e, got);
		end
	endtask

	// One single AHB-Lite transfer, entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdc(input string w, input logic [7:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(w, rd, e);
	endtask

	// Clear the far-side tallies
	task automatic clr_cnt;
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask

	// Event condition word built from its fields
	function automatic logic [31:0] f_evcfg(input logic [1:0] cond,
		input logic [3:0] sel, input logic [1:0] comb,
		input logic [7:0] mask);
		f_evcfg = 32'h0;
		f_evcfg[`EVC_IOCOND +: 2] = cond;
		f_evcfg[`EVC_IOSEL +: 4] = sel;
		f_evcfg[`EVC_COMB +: 2] = comb;
		f_evcfg[`EVC_SMASK +: 8] = mask;
	endfunction

	// Verdict and end of run
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial
	begin
		repeat (8000) @(posedge clk);
		n_errors++;
		print_verdict();
	end

	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rdc("ctrl", `SCTP_CTRL, 32'h00000009);
		rdc("state", `SCTP_STATE, 32'h00000000);
		rdc("hole", 8'h30, 32'h00000000);
		chk("hresp", {31'h0, hresp}, 32'h0);
		// Match and capture registers, random contents
		for (int i = 0; i < 8; i++)
		begin
			n = $random(seed);
			wr(`SCTP_MATCH_BASE + 8'(4 * i), n);
			rdc("match", `SCTP_MATCH_BASE + 8'(4 * i), n);
		end
		// Unified counter, auto limit, up then up-down
		for (int b = 0; b < 2; b++)
		begin
			n = 32'(20 + ($random(seed) & 15));
			wr(`SCTP_CTRL, 32'h00000009);
			wr(`SCTP_MATCH_BASE, n);
			wr(`SCTP_CONFIG, 32'h00000021);
			wr(`SCTP_COUNT, 32'h00000000);
			wr(`SCTP_CTRL, b ? 32'h00000004 : 32'h00000000);
			down = 1'b0;
			prev = 32'h0;
			for (int k = 0; k < 60; k++)
			begin
				bus(1'b0, `SCTP_COUNT, 32'h0);
				chk("bound", 32'(rd <= n), 32'h1);
				if (rd < prev && prev - rd < 32'h8)
					down = 1'b1;
				prev = rd;
			end
			chk("down", 32'(down), 32'(b));
		end
		// Match event: toggle, capture, state load, irq, dma, trigger
		wr(`SCTP_CTRL, 32'h00000009);
		n = 32'(20 + ($random(seed) & 15));
		wr(`SCTP_MATCH_BASE, n);
		wr(`SCTP_REGMODE, 32'h00000002);
		wr(`SCTP_EV_BASE, 32'h00087200);
		wr(`SCTP_EV_BASE + 8'h04, 32'h00002801);
		wr(`SCTP_EVEN, 32'h00000101);
		wr(`SCTP_ADCSEL, 32'h00000000);
		wr(`SCTP_OUTPUT, 32'h00000000);
		wr(`SCTP_STATE, 32'h00000000);
		wr(`SCTP_COUNT, 32'h00000000);
		clr_cnt();
		wr(`SCTP_CTRL, 32'h00000000);
		repeat (4 * n + 20) @(posedge clk);
		@(negedge clk);
		chk("irq", 32'(n_irq), 32'h1);
		chk("dma", 32'(n_dma), 32'h1);
		chk("adc", 32'(n_adc >= 8'h02), 32'h1);
		chk("out0", 32'(outs), 32'h1);
		@(posedge clk);
		rdc("state", `SCTP_STATE, 32'h00000003);
		bus(1'b0, `SCTP_MATCH_BASE + 8'h04, 32'h0);
		chk("capture", rd & 32'h0000FFFF, n);
		// Each selector source raises an input edge event
		wr(`SCTP_EV_BASE + 8'h08, f_evcfg(2'h1, 4'h0, 2'h2, 8'hFF));
		wr(`SCTP_EVEN, 32'h00000200);
		for (int k = 0; k < 7; k++)
		begin
			wr(`SCTP_INSEL, 32'(k));
			clr_cnt();
			src <= 3'(k);
			width <= 3'(1 + ($random(seed) & 3));
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			repeat (12) @(posedge clk);
			@(negedge clk);
			chk("select", 32'(n_dma), 32'h1);
			@(posedge clk);
		end
		// Halt freezes the count
		wr(`SCTP_CTRL, 32'h00000009);
		bus(1'b0, `SCTP_COUNT, 32'h0);
		prev = rd;
		repeat (10) @(posedge clk);
		rdc("halted", `SCTP_COUNT, prev);
		// Unified count carries from the low half into the high half
		wr(`SCTP_CONFIG, 32'h00000001);
		wr(`SCTP_COUNT, 32'h0000FFF0);
		wr(`SCTP_CTRL, 32'h00000000);
		repeat (40) @(posedge clk);
		bus(1'b0, `SCTP_COUNT, 32'h0);
		chk("carry", {16'h0, rd[31:16]}, 32'h1);
		// Split halves: low wraps alone while the high half is halted
		wr(`SCTP_CTRL, 32'h00000009);
		wr(`SCTP_CONFIG, 32'h00000000);
		wr(`SCTP_COUNT, 32'h0005FFF8);
		wr(`SCTP_CTRL, 32'h00000008);
		repeat (20) @(posedge clk);
		bus(1'b0, `SCTP_COUNT, 32'h0);
		chk("split", {16'h0, rd[31:16]}, 32'h5);
		chk("wrap", 32'(rd[15:0] < 16'h0040), 32'h1);
		// Low half counts rising edges of input 0, fed from pin 0
		wr(`SCTP_CTRL, 32'h00000009);
		wr(`SCTP_INSEL, 32'h00000000);
		wr(`SCTP_CONFIG, 32'h00000002);
		wr(`SCTP_COUNT, 32'h00000000);
		wr(`SCTP_CTRL, 32'h00000008);
		src <= 3'h0;
		width <= 3'h1;
		for (int k = 0; k < 3; k++)
		begin
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			repeat (5) @(posedge clk);
		end
		bus(1'b0, `SCTP_COUNT, 32'h0);
		chk("clkin", rd, 32'h00000003);
		print_verdict();
	end
endmodule
